//--- design/fcl_dev_map.vh
// register map, field layout, defaults and limits of the deviation monitor
`ifndef FCL_DEV_MAP_VH
`define FCL_DEV_MAP_VH
// register byte offsets
`define REG_FEED      8'h00
`define REG_RES       8'h04
`define REG_GEAR_MOT  8'h08
`define REG_GEAR_LOAD 8'h0C
`define REG_EG_NUM    8'h10
`define REG_EG_DEN    8'h14
`define REG_THRESH    8'h18
`define REG_MULT      8'h1C
`define REG_MONSEL    8'h20
`define REG_CFG       8'h24
`define REG_STATUS    8'h28
`define REG_MASK      8'h2C
`define REG_DEV       8'h30
`define REG_STATE     8'h34
// reset defaults
`define DEF_FEED      32'h00004E20
`define DEF_RES       32'h000003E8
`define DEF_GEAR      32'h00000001
`define DEF_EGEAR     32'h00000001
`define DEF_THRESH    32'h00000271
`define DEF_MULT      32'h00000000
// limits
`define MIN_ONE       32'h00000001
`define MAX_FEED      32'h000F4240
`define MAX_RES       32'h000186A0
`define MAX_GEAR      32'h0000FFFF
`define MAX_THRESH    32'h40000000
`define MAX_MULT      32'h00000064
`define ZERO32        32'h00000000
// field positions and codes
`define MONSEL1_LSB   0
`define MONSEL2_LSB   8
`define MON_DEV_CODE  8'h07
`define CFG_USE_LSB   0
`define CFG_VSEL_BIT  4
`define USE_OFF       4'h0
`define USE_FWD       4'h1
`define USE_REV       4'h3
`define ST_ALARM_BIT  0
`define ST_REV_BIT    1
// arithmetic
`define FRAC          12
`define NM_PER_UM     32'h000003E8
`define PCT_FULL      8'h64
`define PCT_RECIP     16'hA3D7
`define PCT_SHIFT     22
`define FAC_W         48
`endif

//--- design/full_closed_loop_deviation_monitor.v
// full-closed loop motor/load deviation monitor with register port and alarm
//
// Overview of operation
// - alarm when motor-load deviation exceeds threshold
// - threshold zero disables the deviation alarm
// - threshold 0..max, default 625, immediate
// - multiplier zero uses external position directly
// - carry (1-pct) of rotation deviation forward
// - monitor code 07 outputs deviation, 0.01V/unit
// - velocity source motor/external, applied at power-up
// - linear resolution 1..100000 nm, default 1000
// - motor gear term 1..65535, default 1
// - load gear term 1..65535, default 1
// - feed length 1..1000000 um, default 20000
// - external usage off, forward, or reverse count
`timescale 1ns/1ps
`include "fcl_dev_map.vh"
module full_closed_loop_deviation_monitor #(
  parameter [31:0] ENC_RES = 32'h00004000, // motor encoder counts per revolution
  parameter        MON_W   = 16,           // analog monitor code width, lsb = 0.01 V
  parameter        DIV_W   = 80            // divider width for the scale factors
) (
  input  wire                    core_clk_i,
  input  wire                    arst_n_i,
  input  wire [7:0]              reg_addr_i,
  input  wire [31:0]             reg_wdata_i,
  input  wire                    reg_wr_i,
  input  wire                    reg_rd_i,
  output reg  [31:0]             reg_rdata_o,
  input  wire signed [31:0]      motor_pos_i,
  input  wire                    motor_rev_i,
  input  wire signed [31:0]      motor_vel_i,
  input  wire                    vel_tick_i,
  input  wire                    param_reload_i,
  input  wire                    ext_a_i,
  input  wire                    ext_b_i,
  output reg                     motor_load_deviation_alarm_o,
  output reg                     irq_o,
  output reg  signed [MON_W-1:0] mon1_o,
  output reg  signed [MON_W-1:0] mon2_o,
  output reg  signed [31:0]      vel_fb_o
);

  // divider states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_K    = 2'b01;
  localparam [1:0] ST_G    = 2'b10;
  localparam [6:0] DIV_LAST = DIV_W - 1;
  localparam [6:0] DIV_LOAD = {7{1'b1}}; // marks the operand-load cycle, never a step count

  // clamp a setting into its legal range
  function [31:0] clampu;
    input [31:0] x;
    input [31:0] lo;
    input [31:0] hi;
    begin
      clampu = (x < lo) ? lo : ((x > hi) ? hi : x);
    end
  endfunction

  // fixed-point scale, factor carries FRAC fraction bits
  function signed [31:0] scale;
    input signed [31:0]  x;
    input [`FAC_W-1:0]   f;
    reg signed [80:0]    p;
    begin
      p = x * $signed({1'b0, f});
      scale = p[`FRAC+31:`FRAC];
    end
  endfunction

  // quotient saturated into the factor width
  function [`FAC_W-1:0] sat_fac;
    input [DIV_W-1:0] q;
    begin
      sat_fac = (|q[DIV_W-1:`FAC_W]) ? {`FAC_W{1'b1}} : q[`FAC_W-1:0];
    end
  endfunction

  // saturate the deviation into the monitor code range
  function signed [MON_W-1:0] sat_mon;
    input signed [31:0] x;
    reg signed [31:0]   hi;
    begin
      hi = (32'sd1 <<< (MON_W - 1)) - 32'sd1;
      if (x > hi) begin
        sat_mon = hi[MON_W-1:0];
      end else if (x < -hi - 32'sd1) begin
        sat_mon = ~hi[MON_W-1:0];
      end else begin
        sat_mon = x[MON_W-1:0];
      end
    end
  endfunction

  // software copies of the settings
  reg [31:0] feed_q;            // ext_feed_length, um/rev
  reg [31:0] res_q;             // ext_linear_resolution, nm/count
  reg [31:0] gm_q;              // gear_motor_side
  reg [31:0] gl_q;              // gear_load_side
  reg [31:0] egn_q;             // elec_gear_numerator
  reg [31:0] egd_q;             // elec_gear_denominator
  reg [31:0] thr_q;             // deviation_alarm_threshold, live
  reg [31:0] mult_q;            // rotation_deviation_multiplier, live
  reg [15:0] monsel_q;          // analog_monitor1/2_select, live
  reg [4:0]  cfg_q;             // ext_encoder_usage and velocity_feedback_select
  reg [1:0]  mask_q;            // interrupt mask
  reg [1:0]  st_q;              // sticky event status
  // copies that act, loaded only at power-up
  reg [31:0] a_feed_q;
  reg [31:0] a_res_q;
  reg [31:0] a_gm_q;
  reg [31:0] a_gl_q;
  reg [31:0] a_egn_q;
  reg [31:0] a_egd_q;
  reg [3:0]  a_use_q;
  reg        a_vsel_q;
  // scale factors and divider
  reg [`FAC_W-1:0] k_q;         // external count -> motor count
  reg [`FAC_W-1:0] g_q;         // motor count -> control unit
  reg [1:0]        div_st_q;
  reg [6:0]        div_cnt_q;
  reg [DIV_W-1:0]  div_num_q;
  reg [DIV_W-1:0]  div_den_q;
  reg [DIV_W-1:0]  div_rem_q;
  reg [DIV_W-1:0]  div_quo_q;
  // external encoder
  reg [2:0]         a_s_q;
  reg [2:0]         b_s_q;
  reg               a_f_q;
  reg               b_f_q;
  reg signed [31:0] ext_cnt_q;
  // deviation pipeline
  reg signed [31:0] ext_mot_q;  // external position in motor counts
  reg signed [31:0] corr_q;     // carried rotation correction
  reg signed [31:0] dev_cnt_q;  // deviation in motor counts
  reg signed [31:0] dev_ctl_q;  // deviation in control units
  reg signed [31:0] ext_prev_q;
  reg signed [31:0] ext_vel_q;

  // divider step, one quotient bit per cycle
  wire [DIV_W-1:0] rem_sh = {div_rem_q[DIV_W-2:0], div_num_q[DIV_W-1]};
  wire             fit    = rem_sh >= div_den_q;
  wire [DIV_W-1:0] rem_nx = fit ? (rem_sh - div_den_q) : rem_sh;
  wire [DIV_W-1:0] quo_nx = {div_quo_q[DIV_W-2:0], fit};

  // numerators and divisors of both factors
  wire [DIV_W-1:0] k_num = (ENC_RES * a_res_q * a_gm_q) << `FRAC;
  wire [DIV_W-1:0] k_den = `NM_PER_UM * a_feed_q * a_gl_q;
  wire [DIV_W-1:0] g_num = a_egd_q << `FRAC;
  wire [DIV_W-1:0] g_den = {{(DIV_W-32){1'b0}}, a_egn_q};

  wire wr_st = reg_wr_i && (reg_addr_i == `REG_STATUS);

  // quadrature decode on filtered levels
  wire a_new = (a_s_q[1] == a_s_q[2]) ? a_s_q[2] : a_f_q;
  wire b_new = (b_s_q[1] == b_s_q[2]) ? b_s_q[2] : b_f_q;
  wire step  = (a_new ^ a_f_q) ^ (b_new ^ b_f_q);
  wire up    = a_new ^ b_f_q;

  // absolute deviation against threshold
  wire [31:0] dev_abs  = dev_ctl_q[31] ? (~dev_ctl_q + 32'h00000001) : dev_ctl_q;
  wire        alarm_nx = (thr_q != `ZERO32) && (dev_abs > thr_q);

  wire [7:0] pct_keep = `PCT_FULL - mult_q[7:0];
  wire [1:0] st_set   = {motor_rev_i, alarm_nx & ~motor_load_deviation_alarm_o};
  wire [1:0] st_d     = (st_q & ~(wr_st ? reg_wdata_i[1:0] : 2'b00)) | st_set;

  // rotation correction, share (100 - pct) of the raw deviation
  wire signed [31:0] raw_dev = motor_pos_i - ext_mot_q;
  wire signed [63:0] corr_p  = raw_dev * $signed({1'b0, pct_keep})
                               * $signed({1'b0, `PCT_RECIP});
  wire signed [63:0] corr_sh = corr_p >>> `PCT_SHIFT;

  // software writes; live settings act at once, others wait for power-up
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      feed_q   <= `DEF_FEED;
      res_q    <= `DEF_RES;
      gm_q     <= `DEF_GEAR;
      gl_q     <= `DEF_GEAR;
      egn_q    <= `DEF_EGEAR;
      egd_q    <= `DEF_EGEAR;
      thr_q    <= `DEF_THRESH;
      mult_q   <= `DEF_MULT;
      monsel_q <= 16'h0000;
      cfg_q    <= 5'h00;
      mask_q   <= 2'b00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_FEED:      feed_q   <= reg_wdata_i;
        `REG_RES:       res_q    <= reg_wdata_i;
        `REG_GEAR_MOT:  gm_q     <= reg_wdata_i;
        `REG_GEAR_LOAD: gl_q     <= reg_wdata_i;
        `REG_EG_NUM:    egn_q    <= reg_wdata_i;
        `REG_EG_DEN:    egd_q    <= reg_wdata_i;
        `REG_THRESH:    thr_q    <= clampu(reg_wdata_i, `ZERO32, `MAX_THRESH);
        `REG_MULT:      mult_q   <= clampu(reg_wdata_i, `ZERO32, `MAX_MULT);
        `REG_MONSEL:    monsel_q <= reg_wdata_i[15:0];
        `REG_CFG:       cfg_q    <= reg_wdata_i[4:0];
        `REG_MASK:      mask_q   <= reg_wdata_i[1:0];
        default: ;      // status, read-only or unmapped: no setting written; a status write clears bits through wr_st
      endcase
    end
  end

  // power-up copy; reset itself is a power-up with the defaults
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_feed_q <= `DEF_FEED;
      a_res_q  <= `DEF_RES;
      a_gm_q   <= `DEF_GEAR;
      a_gl_q   <= `DEF_GEAR;
      a_egn_q  <= `DEF_EGEAR;
      a_egd_q  <= `DEF_EGEAR;
      a_use_q  <= `USE_OFF;
      a_vsel_q <= 1'b0;
    end else if (param_reload_i) begin
      a_feed_q <= clampu(feed_q, `MIN_ONE, `MAX_FEED);
      a_res_q  <= clampu(res_q, `MIN_ONE, `MAX_RES);
      a_gm_q   <= clampu(gm_q, `MIN_ONE, `MAX_GEAR);
      a_gl_q   <= clampu(gl_q, `MIN_ONE, `MAX_GEAR);
      a_egn_q  <= clampu(egn_q, `MIN_ONE, 32'hFFFFFFFF);
      a_egd_q  <= clampu(egd_q, `MIN_ONE, 32'hFFFFFFFF);
      a_use_q  <= cfg_q[`CFG_USE_LSB+3:`CFG_USE_LSB];
      a_vsel_q <= cfg_q[`CFG_VSEL_BIT];
    end
  end

  // factor divider; restarts after reset and each power-up copy
  // the old factors keep acting until the new ones are ready
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_st_q  <= ST_K;
      div_cnt_q <= DIV_LOAD;
      div_num_q <= {DIV_W{1'b0}};
      div_den_q <= {DIV_W{1'b1}};
      div_rem_q <= {DIV_W{1'b0}};
      div_quo_q <= {DIV_W{1'b0}};
      k_q       <= {`FAC_W{1'b0}};
      g_q       <= {`FAC_W{1'b0}};
    end else if (param_reload_i) begin
      div_st_q  <= ST_K;
      div_cnt_q <= DIV_LOAD;
    end else begin
      case (div_st_q)
        ST_IDLE: ;
        ST_K, ST_G: begin
          if (div_cnt_q == DIV_LOAD) begin
            // load operands one cycle before stepping
            div_num_q <= (div_st_q == ST_K) ? k_num : g_num;
            div_den_q <= (div_st_q == ST_K) ? k_den : g_den;
            div_rem_q <= {DIV_W{1'b0}};
            div_quo_q <= {DIV_W{1'b0}};
            div_cnt_q <= 7'h00;
          end else begin
            div_num_q <= {div_num_q[DIV_W-2:0], 1'b0};
            div_rem_q <= rem_nx;
            div_quo_q <= quo_nx;
            div_cnt_q <= div_cnt_q + 7'h01;
            // all DIV_W quotient bits are in after the step at DIV_LAST
            if (div_cnt_q == DIV_LAST) begin
              if (div_st_q == ST_K) begin
                k_q       <= sat_fac(quo_nx);
                div_st_q  <= ST_G;
                div_cnt_q <= DIV_LOAD;
              end else begin
                g_q      <= sat_fac(quo_nx);
                div_st_q <= ST_IDLE;
              end
            end
          end
        end
        default: div_st_q <= ST_IDLE;
      endcase
    end
  end

  // external encoder pins: three-stage sync, then quadrature count
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_s_q     <= 3'b000;
      b_s_q     <= 3'b000;
      a_f_q     <= 1'b0;
      b_f_q     <= 1'b0;
      ext_cnt_q <= 32'sh00000000;
    end else begin
      a_s_q <= {a_s_q[1:0], ext_a_i};
      b_s_q <= {b_s_q[1:0], ext_b_i};
      a_f_q <= a_new;
      b_f_q <= b_new;
      // a double change is a lost step and is not counted
      if (a_use_q == `USE_FWD && step) begin
        ext_cnt_q <= up ? ext_cnt_q + 32'sh1 : ext_cnt_q - 32'sh1;
      end else if (a_use_q == `USE_REV && step) begin
        ext_cnt_q <= up ? ext_cnt_q - 32'sh1 : ext_cnt_q + 32'sh1;
      end
    end
  end

  // deviation pipeline, one stage per cycle
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_mot_q  <= 32'sh00000000;
      corr_q     <= 32'sh00000000;
      dev_cnt_q  <= 32'sh00000000;
      dev_ctl_q  <= 32'sh00000000;
      ext_prev_q <= 32'sh00000000;
      ext_vel_q  <= 32'sh00000000;
    end else begin
      ext_mot_q <= scale(ext_cnt_q, k_q);
      if (mult_q == `ZERO32) begin
        corr_q <= 32'sh00000000;
      end else if (motor_rev_i) begin
        corr_q <= corr_sh[31:0];
      end
      // with no external encoder there is nothing to compare against
      if (a_use_q == `USE_OFF) begin
        dev_cnt_q <= 32'sh00000000;
      end else begin
        dev_cnt_q <= motor_pos_i - (ext_mot_q + corr_q);
      end
      dev_ctl_q <= scale(dev_cnt_q, g_q);
      if (vel_tick_i) begin
        ext_vel_q  <= ext_mot_q - ext_prev_q;
        ext_prev_q <= ext_mot_q;
      end
    end
  end

  // alarm, status, interrupt, monitor and velocity outputs
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      motor_load_deviation_alarm_o <= 1'b0;
      st_q     <= 2'b00;
      irq_o    <= 1'b0;
      mon1_o   <= {MON_W{1'b0}};
      mon2_o   <= {MON_W{1'b0}};
      vel_fb_o <= 32'sh00000000;
    end else begin
      motor_load_deviation_alarm_o <= alarm_nx;
      st_q  <= st_d;                            // set wins over clear
      irq_o <= |(st_d & mask_q);
      mon1_o <= (monsel_q[`MONSEL1_LSB+7:`MONSEL1_LSB] == `MON_DEV_CODE)
                ? sat_mon(dev_ctl_q) : {MON_W{1'b0}};
      mon2_o <= (monsel_q[`MONSEL2_LSB+7:`MONSEL2_LSB] == `MON_DEV_CODE)
                ? sat_mon(dev_ctl_q) : {MON_W{1'b0}};
      vel_fb_o <= a_vsel_q ? ext_vel_q : motor_vel_i;
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_FEED:      reg_rdata_o <= feed_q;
        `REG_RES:       reg_rdata_o <= res_q;
        `REG_GEAR_MOT:  reg_rdata_o <= gm_q;
        `REG_GEAR_LOAD: reg_rdata_o <= gl_q;
        `REG_EG_NUM:    reg_rdata_o <= egn_q;
        `REG_EG_DEN:    reg_rdata_o <= egd_q;
        `REG_THRESH:    reg_rdata_o <= thr_q;
        `REG_MULT:      reg_rdata_o <= mult_q;
        `REG_MONSEL:    reg_rdata_o <= {16'h0000, monsel_q};
        `REG_CFG:       reg_rdata_o <= {27'h0000000, cfg_q};
        `REG_STATUS:    reg_rdata_o <= {30'h00000000, st_q};
        `REG_MASK:      reg_rdata_o <= {30'h00000000, mask_q};
        `REG_DEV:       reg_rdata_o <= dev_ctl_q;
        `REG_STATE:     reg_rdata_o <= {27'h0000000, a_vsel_q, a_use_q == `USE_OFF,
                                        div_st_q, motor_load_deviation_alarm_o};
        default:        reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule

//--- test/fcl_dev_props.sv
// checker: register echo, alarm gating, interrupt and output selection
`timescale 1ns/1ps
`include "fcl_dev_map.vh"
module fcl_dev_props #(
  parameter MON_W = 16 // monitor code width
) (
  input wire                    core_clk_i,
  input wire                    arst_n_i,
  input wire [7:0]              reg_addr_i,
  input wire [31:0]             reg_wdata_i,
  input wire                    reg_wr_i,
  input wire                    reg_rd_i,
  input wire [31:0]             reg_rdata_o,
  input wire signed [31:0]      motor_vel_i,
  input wire                    param_reload_i,
  input wire                    motor_load_deviation_alarm_o,
  input wire                    irq_o,
  input wire signed [MON_W-1:0] mon1_o,
  input wire signed [MON_W-1:0] mon2_o,
  input wire signed [31:0]      vel_fb_o
);
  reg [31:0] thr_q; // threshold in force
  reg [7:0]  mul_q; // multiplier after clamp
  reg [15:0] sel_q; // monitor selectors
  reg [31:0] msk_q; // interrupt mask
  reg        cfv_q; // velocity select as written
  reg        act_q; // velocity select taken at power-up
  // shadow of the settings, clamped as the port clamps them
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      thr_q <= `DEF_THRESH;
      mul_q <= 8'h00;
      sel_q <= 16'h0000;
      msk_q <= 32'h00000000;
      cfv_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `REG_THRESH)
        thr_q <= (reg_wdata_i > `MAX_THRESH) ? `MAX_THRESH : reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `REG_MULT)
        mul_q <= (reg_wdata_i > `MAX_MULT) ? 8'h64 : reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == `REG_MONSEL)
        sel_q <= reg_wdata_i[15:0];
      if (reg_wr_i && reg_addr_i == `REG_MASK)
        msk_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `REG_CFG)
        cfv_q <= reg_wdata_i[`CFG_VSEL_BIT];
      // only a power-up event moves the velocity source
      if (param_reload_i)
        act_q <= cfv_q;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h00000000)
    else $error("read data not zero outside a read");
  AST_THR_RD: assert property (reg_rd_i && reg_addr_i == `REG_THRESH |=> reg_rdata_o == thr_q)
    else $error("threshold read back wrong");
  AST_MUL_RD: assert property (reg_rd_i && reg_addr_i == `REG_MULT |=> reg_rdata_o == {24'h000000, mul_q})
    else $error("multiplier read back wrong");
  AST_THR_ZERO: assert property ((thr_q == 32'h00000000) [*2] |=> !motor_load_deviation_alarm_o)
    else $error("alarm with zero threshold");
  AST_MON1_OFF: assert property ((sel_q[7:0] != `MON_DEV_CODE) [*2] |=> mon1_o == 0)
    else $error("monitor 1 active without its code");
  AST_MON2_OFF: assert property ((sel_q[15:8] != `MON_DEV_CODE) [*2] |=> mon2_o == 0)
    else $error("monitor 2 active without its code");
  AST_IRQ_MASK: assert property ((msk_q == 32'h00000000) [*2] |=> !irq_o)
    else $error("interrupt with all sources masked");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(msk_q) != 32'h00000000)
    else $error("interrupt rose with empty mask");
  AST_ALARM_IRQ: assert property ($rose(motor_load_deviation_alarm_o) && msk_q[0] |-> ##[0:3] irq_o)
    else $error("alarm did not raise the interrupt");
  AST_VEL_MOT: assert property ((!act_q) [*2] |=> vel_fb_o == $past(motor_vel_i))
    else $error("velocity feedback not from motor");
  cover property ($rose(motor_load_deviation_alarm_o));
  cover property ($rose(irq_o));
  cover property (param_reload_i ##1 act_q);
endmodule
bind full_closed_loop_deviation_monitor fcl_dev_props #(.MON_W(MON_W)) fcl_dev_props_inst (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .motor_vel_i(motor_vel_i), .param_reload_i(param_reload_i),
  .motor_load_deviation_alarm_o(motor_load_deviation_alarm_o), .irq_o(irq_o),
  .mon1_o(mon1_o), .mon2_o(mon2_o), .vel_fb_o(vel_fb_o));

//--- test/fcl_quad_enc_model.sv
// load-side linear scale model: quadrature pins walking toward a target
`timescale 1ns/1ps
module fcl_quad_enc_model (
  input  wire               core_clk_i,
  input  wire               arst_n_i,
  input  wire signed [31:0] target_i, // wanted scale count
  output reg  signed [31:0] pos_o,    // count reached so far
  output wire               ext_a_o,
  output wire               ext_b_o
);
  reg [1:0] div_q; // one step per four clocks, slow enough for the pin filter
  // step the count one state at a time, never skipping a phase
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 2'h0;
      pos_o <= 32'sh0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3 && pos_o < target_i)
        pos_o <= pos_o + 32'sh1;
      else if (div_q == 2'h3 && pos_o > target_i)
        pos_o <= pos_o - 32'sh1;
    end
  end
  // gray phase: a leads b while counting up
  assign ext_a_o = pos_o[1] ^ pos_o[0];
  assign ext_b_o = pos_o[1];
endmodule

//--- test/full_closed_loop_deviation_monitor_test.sv
// self-checking bench for the deviation monitor
`timescale 1ns/1ps
`include "fcl_dev_map.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %0d got %0d", n, e, s); end end
module full_closed_loop_deviation_monitor_test;
  logic               core_clk_i = 1'b0;
  logic               arst_n_i = 1'b0;
  logic [7:0]         reg_addr_i = 8'h00;
  logic [31:0]        reg_wdata_i = 32'h00000000;
  logic               reg_wr_i = 1'b0;
  logic               reg_rd_i = 1'b0;
  wire  [31:0]        reg_rdata_o;
  logic signed [31:0] motor_pos_i = 32'sh0; // bench plays the motor encoder
  logic               motor_rev_i = 1'b0;
  logic signed [31:0] motor_vel_i = 32'sh0;
  logic               vel_tick_i = 1'b0;
  logic               param_reload_i = 1'b0;
  logic signed [31:0] tgt = 32'sh0;         // scale target
  wire  signed [31:0] scale_pos;
  wire                ext_a, ext_b, alarm, irq;
  wire  signed [15:0] mon1, mon2;
  wire  signed [31:0] vel_fb;
  integer             failures = 0;
  integer             comparisons = 0;
  integer             cyc = 0;
  logic [31:0]        v0, v1;
  // ENC_RES equal to feed*1000/res later makes one scale count one motor count
  full_closed_loop_deviation_monitor #(.ENC_RES(32'h000003E8))
    full_closed_loop_deviation_monitor_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .motor_pos_i(motor_pos_i), .motor_rev_i(motor_rev_i),
    .motor_vel_i(motor_vel_i), .vel_tick_i(vel_tick_i), .param_reload_i(param_reload_i),
    .ext_a_i(ext_a), .ext_b_i(ext_b), .motor_load_deviation_alarm_o(alarm), .irq_o(irq),
    .mon1_o(mon1), .mon2_o(mon2), .vel_fb_o(vel_fb));
  fcl_quad_enc_model fcl_quad_enc_model_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .target_i(tgt), .pos_o(scale_pos),
    .ext_a_o(ext_a), .ext_b_o(ext_b));
  // 4 ns clock
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic w(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe; taken at its closing edge
  task automatic rd(input [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic rdc(input [7:0] a, input [31:0] e);
    rd(a, v0);
    `CHK("register", e, v0)
  endtask
  // power-up event; the factor divider needs about 162 cycles afterwards
  task automatic reload;
    @(posedge core_clk_i);
    param_reload_i <= 1'b1;
    @(posedge core_clk_i);
    param_reload_i <= 1'b0;
    w(400);
  endtask
  task automatic mv(input signed [31:0] t);
    tgt <= t;
    for (int i = 0; i < 200 && scale_pos != t; i++) @(posedge core_clk_i);
    w(20);
  endtask
  task automatic dmove(input signed [31:0] t, input signed [31:0] d);
    rd(`REG_DEV, v0);
    mv(t);
    rd(`REG_DEV, v1);
    `CHK("dev step", d, v1 - v0)
  endtask
  task automatic pulse_rev;
    @(posedge core_clk_i);
    motor_rev_i <= 1'b1;
    @(posedge core_clk_i);
    motor_rev_i <= 1'b0;
    w(10);
  endtask
  task automatic tick;
    @(posedge core_clk_i);
    vel_tick_i <= 1'b1;
    @(posedge core_clk_i);
    vel_tick_i <= 1'b0;
    w(8);
  endtask
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      test_done;
    end
  end
  initial begin
    w(10);
    arst_n_i <= 1'b1;
    rdc(`REG_THRESH, `DEF_THRESH);
    rdc(`REG_RES, `DEF_RES);
    rdc(`REG_GEAR_MOT, `DEF_GEAR);
    rdc(`REG_GEAR_LOAD, `DEF_GEAR);
    rdc(`REG_FEED, `DEF_FEED);
    rdc(`REG_CFG, 32'h00000000);
    rdc(`REG_MULT, `DEF_MULT);
    rdc(8'h3C, 32'h00000000);
    tend("defaults");
    // scale unused: a large motor offset must not show up
    w(200);
    motor_pos_i <= 32'sd1000;
    mv(32'sd8);
    rd(`REG_DEV, v0);
    `CHK("dev off", 32'h00000000, v0)
    `CHK("alarm off", 1'b0, alarm)
    mv(32'sd0);
    motor_pos_i <= 32'sd0;
    wr(`REG_FEED, 32'h000003E8);
    wr(`REG_CFG, {28'h0000000, `USE_FWD});
    wr(`REG_MASK, 32'h00000001);
    reload;
    rdc(`REG_FEED, 32'h000003E8);
    mv(32'sd10);
    rd(`REG_DEV, v0);
    `CHK("dev", -32'sd10, v0)
    motor_pos_i <= 32'sd636;
    w(12);
    `CHK("alarm", 1'b1, alarm)
    `CHK("irq", 1'b1, irq)
    rdc(`REG_STATUS, 32'h00000001);
    wr(`REG_MONSEL, 32'h00000707);
    w(4);
    `CHK("mon1", 16'sd626, mon1)
    `CHK("mon2", 16'sd626, mon2)
    wr(`REG_MASK, 32'h00000000);
    w(3);
    `CHK("irq masked", 1'b0, irq)
    wr(`REG_STATUS, 32'h00000001);
    rdc(`REG_STATUS, 32'h00000000);
    wr(`REG_MASK, 32'h00000001);
    motor_pos_i <= 32'sd635;
    w(8);
    `CHK("alarm at limit", 1'b0, alarm)
    motor_pos_i <= 32'sd636;
    w(8);
    `CHK("irq again", 1'b1, irq)
    wr(`REG_THRESH, 32'h00000000);
    w(4);
    `CHK("alarm zero", 1'b0, alarm)
    wr(`REG_THRESH, 32'h7FFFFFFF);
    rdc(`REG_THRESH, `MAX_THRESH);
    wr(`REG_THRESH, `DEF_THRESH);
    wr(`REG_MONSEL, 32'h00000700);
    w(4);
    `CHK("mon1 off", 16'sd0, mon1)
    `CHK("mon2 on", 16'sd626, mon2)
    tend("alarm");
    wr(`REG_MULT, 32'h000000C8);
    rdc(`REG_MULT, `MAX_MULT);
    wr(`REG_MULT, 32'h00000032);
    pulse_rev;
    rd(`REG_DEV, v0);
    `CHK("dev carried", 1'b1, v0 >= 32'd312 && v0 <= 32'd315)
    wr(`REG_MULT, 32'h00000000);
    pulse_rev;
    rd(`REG_DEV, v0);
    `CHK("dev direct", 32'sd626, v0)
    tend("multiplier");
    // direction and scale changes wait for the power-up event
    wr(`REG_CFG, {28'h0000000, `USE_REV});
    dmove(32'sd14, -32'sd4);
    reload;
    dmove(32'sd18, 32'sd4);
    wr(`REG_FEED, 32'h000007D0);
    dmove(32'sd22, 32'sd4);
    reload;
    dmove(32'sd30, 32'sd4);
    tend("scale");
    motor_vel_i <= 32'sd1234;
    wr(`REG_CFG, 32'h00000013);
    tick;
    tick;
    `CHK("vel motor", 32'sd1234, vel_fb)
    reload;
    tick;
    mv(32'sd34);
    tick;
    `CHK("vel scale", -32'sd2, vel_fb)
    rdc(`REG_STATE, 32'h00000011);
    tend("velocity");
    test_done;
  end
endmodule
